/* File: core/rwc_pkg.sv */
package rwc_pkg;

  // register addresses on the plain register port
  localparam logic [7:0] WD_CTRL_ADDR  = 8'h60;
  localparam logic [7:0] REF_CTRL_ADDR = 8'h61;
  localparam logic [7:0] RST_STAT_ADDR = 8'h62;

  // watchdog control register fields
  localparam int WC_IRQ_FLAG  = 7;
  localparam int WC_IRQ_EN    = 6;
  localparam int WC_PRESCALE3 = 5;
  localparam int WC_CHG_EN    = 4;
  localparam int WC_RST_EN    = 3;

  // reference control register fields
  localparam int RC_CMP_REF_SEL = 0;
  localparam int RC_ADC_EN      = 1;

  // reset status register fields
  localparam int RS_POWER_ON = 0;
  localparam int RS_EXTERNAL = 1;
  localparam int RS_BROWNOUT = 2;
  localparam int RS_WATCHDOG = 3;
  localparam int RS_SCAN     = 4;

  // synchroniser lanes
  localparam int SY_POWER_OK = 0;
  localparam int SY_EXT_N    = 1;
  localparam int SY_BROWNOUT = 2;
  localparam int SY_SCAN     = 3;
  localparam int SY_OSC      = 4;

  localparam logic [7:0] WD_CTRL_RESET  = 8'h00;
  localparam logic [1:0] REF_CTRL_RESET = 2'h0;
  localparam logic [4:0] RST_STAT_RESET = 5'h01;
  localparam logic [4:0] SYNC_IDLE      = 5'h03;

  // change-enable stays open for this many clock cycles
  localparam logic [2:0] CHG_WINDOW = 3'h4;
  localparam logic [3:0] PRESCALE_MAX = 4'h9;

  // timing
  localparam longint CLK_HZ             = 200_000_000;
  localparam longint WD_OSC_HZ          = 128_000;
  localparam longint WD_MIN_TIMEOUT_MS  = 16;
  localparam longint WD_BASE_TICKS      =
    WD_OSC_HZ * WD_MIN_TIMEOUT_MS / 1000;
  localparam longint STARTUP_BASE_NS    = 4000;
  localparam longint STARTUP_BASE_CYCLES =
    (STARTUP_BASE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

endpackage : rwc_pkg

/* File: core/rwc_reset_watchdog.sv */
// How it works
// - reset returns registers; core restarts at vector
// - any source but the watchdog resets sys_rst_n_out and irq_req_out without a clock
// - delay counter stretches reset after sources clear
// - five sources: power, pin, watchdog, brownout, scan
// - supply rise starts delay; drop resets immediately
// - long low pin pulse resets, clock or not
// - pin release runs the delay before start
// - enabled brownout resets now; clears via delay
// - scan reset bit holds reset while one
// - watchdog reset is one-cycle pulse, delay after
// - reference on for brownout, comparator, converter
// - watchdog counts slow oscillator ticks to time-out
// - restart instruction clears the watchdog counter
// - time-out selectable from 16ms to 8s
// - interrupt mode raises a wake-capable interrupt
// - combined mode: interrupt first, reset next
// - always-on fuse forces reset mode, irq off
// - window write sets reset-enable and prescale
// - change-enable clears itself after four cycles
// - reset-enable reads set while watchdog flag set
// - irq flag set on expiry, cleared ack/write-one
// - vector in combined mode clears irq enable
//
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module rwc_reset_watchdog
  import rwc_pkg::*;
#(
  parameter int unsigned DLY_BASE = 32'(STARTUP_BASE_CYCLES),
  parameter int unsigned WD_BASE  = 32'(WD_BASE_TICKS),
  parameter int unsigned DLY_W    = 24,
  parameter int unsigned WD_W     = 24
) (
  input  wire logic       ref_clk_in,
  input  wire logic       rstn_in,
  input  wire logic       power_ok_in,
  input  wire logic       ext_rst_n_in,
  input  wire logic       brownout_low_in,
  input  wire logic       brownout_detector_en_in,
  input  wire logic       scan_rst_in,
  input  wire logic       wd_osc_in,
  input  wire logic [1:0] startup_time_fuse_in,
  input  wire logic [3:0] clock_select_fuse_in,
  input  wire logic       watchdog_always_on_fuse_in,
  input  wire logic       wd_restart_in,
  input  wire logic       irq_ack_in,
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wr_data_in,
  input  wire logic       wr_en_in,
  input  wire logic       rd_en_in,
  output logic      [7:0] rd_data_out,
  output logic            sys_rst_n_out,
  output logic            irq_req_out,
  output logic            ref_en_out
);

  // combined asynchronous reset sources; the external pin pulse filter
  // is analog and sits outside this block
  wire src_active = !power_ok_in | !ext_rst_n_in |
                    (brownout_low_in & brownout_detector_en_in) |
                    scan_rst_in;
  wire hold_rst_n = rstn_in & !src_active;

  logic [4:0]       sync_a;
  logic [4:0]       sync_b;
  logic             osc_prev;
  logic [DLY_W-1:0] dly_cnt;
  logic             wd_rst_pulse;
  logic             irq_flag;
  logic             irq_en;
  logic             rst_en;
  logic             chg_en;
  logic [2:0]       chg_cnt;
  logic [3:0]       prescale;
  logic [WD_W-1:0]  wd_cnt;
  logic [1:0]       ref_ctrl;
  logic [4:0]       rst_flags;

  // level synchronisers; only the second stage is read
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sync_a   <= SYNC_IDLE;
      sync_b   <= SYNC_IDLE;
      osc_prev <= 1'b0;
    end else begin
      sync_a   <= {wd_osc_in, scan_rst_in,
                   brownout_low_in & brownout_detector_en_in,
                   ext_rst_n_in, power_ok_in};
      sync_b   <= sync_a;
      osc_prev <= sync_b[SY_OSC];
    end
  end

  wire osc_tick = sync_b[SY_OSC] & !osc_prev;

  // delay counter length from the start-up and clock-select fuses
  wire [2:0]       dly_shift  = {clock_select_fuse_in[3],
                                 startup_time_fuse_in};
  wire [DLY_W-1:0] dly_target = DLY_W'(DLY_BASE) << dly_shift;
  wire [DLY_W-1:0] dly_last   = dly_target - 1'b1;
  wire             dly_done   = (dly_cnt == dly_last);

  // internal reset: set at once by any source but the watchdog, whose pulse
  // sets it on the next clock edge; released only when the delay counter
  // has run out after every source went quiet
  always_ff @(posedge ref_clk_in or negedge hold_rst_n) begin
    if (!hold_rst_n) begin
      sys_rst_n_out <= 1'b0;
      dly_cnt       <= '0;
    end else if (wd_rst_pulse) begin
      sys_rst_n_out <= 1'b0;
      dly_cnt       <= '0;
    end else if (!sys_rst_n_out) begin
      if (dly_done) begin
        sys_rst_n_out <= 1'b1;
      end else begin
        dly_cnt <= dly_cnt + 1'b1;
      end
    end
  end

  // register decode
  wire wr_wd  = wr_en_in && (addr_in == WD_CTRL_ADDR);
  wire wr_ref = wr_en_in && (addr_in == REF_CTRL_ADDR);
  wire wr_st  = wr_en_in && (addr_in == RST_STAT_ADDR);
  wire wr_ce  = wr_data_in[WC_CHG_EN];
  wire wr_re  = wr_data_in[WC_RST_EN];
  wire [3:0] wr_prescale = {wr_data_in[WC_PRESCALE3], wr_data_in[2:0]};

  wire open_seq = wr_wd && wr_ce && wr_re && !chg_en;
  wire win_wr   = wr_wd && chg_en && !wr_ce;

  wire fuse_on   = watchdog_always_on_fuse_in;
  wire wd_flag   = rst_flags[RS_WATCHDOG];
  wire re_eff    = rst_en | wd_flag | fuse_on;
  wire ie_eff    = irq_en & !fuse_on;
  wire wd_run    = re_eff | ie_eff;

  wire [3:0]      ps_sel   = (prescale > PRESCALE_MAX) ? PRESCALE_MAX
                                                       : prescale;
  wire [WD_W-1:0] wd_limit = WD_W'(WD_BASE) << ps_sel;
  wire [WD_W-1:0] wd_last  = wd_limit - 1'b1;

  wire wd_exp   = wd_run && osc_tick && !wd_restart_in &&
                  (wd_cnt == wd_last);
  // combined mode: a pending, unserviced interrupt turns the next
  // expiry into a reset
  wire exp_irq  = wd_exp && ie_eff && !(re_eff && irq_flag);
  wire exp_rst  = wd_exp && re_eff && !(ie_eff && !irq_flag);

  // next values of the watchdog control bits
  logic next_rst_en;
  logic next_irq_en;
  logic next_irq_flag;

  always_comb begin
    if (fuse_on) begin
      next_rst_en = 1'b1;
    end else if (win_wr) begin
      next_rst_en = wr_re | wd_flag;
    end else if (wr_wd && wr_re) begin
      next_rst_en = 1'b1;
    end else begin
      next_rst_en = rst_en;
    end
  end

  always_comb begin
    if (fuse_on) begin
      next_irq_en = 1'b0;
    end else if (wr_wd) begin
      next_irq_en = wr_data_in[WC_IRQ_EN];
    end else if (irq_ack_in && re_eff) begin
      next_irq_en = 1'b0;
    end else begin
      next_irq_en = irq_en;
    end
  end

  // a new expiry wins over a clear in the same cycle
  always_comb begin
    if (exp_irq) begin
      next_irq_flag = 1'b1;
    end else if (irq_ack_in || (wr_wd && wr_data_in[WC_IRQ_FLAG])) begin
      next_irq_flag = 1'b0;
    end else begin
      next_irq_flag = irq_flag;
    end
  end

  wire [3:0] next_prescale = win_wr ? wr_prescale : prescale;

  // watchdog control state: an I/O register, cleared by internal reset
  always_ff @(posedge ref_clk_in or negedge sys_rst_n_out) begin
    if (!sys_rst_n_out) begin
      irq_flag    <= WD_CTRL_RESET[WC_IRQ_FLAG];
      irq_en      <= WD_CTRL_RESET[WC_IRQ_EN];
      rst_en      <= WD_CTRL_RESET[WC_RST_EN];
      prescale    <= {WD_CTRL_RESET[WC_PRESCALE3], WD_CTRL_RESET[2:0]};
      irq_req_out <= 1'b0;
      ref_ctrl    <= REF_CTRL_RESET;
    end else begin
      irq_flag    <= next_irq_flag;
      irq_en      <= next_irq_en;
      rst_en      <= next_rst_en;
      prescale    <= next_prescale;
      irq_req_out <= next_irq_flag & next_irq_en & !fuse_on;
      ref_ctrl    <= wr_ref ? wr_data_in[1:0] : ref_ctrl;
    end
  end

  // change window: open for exactly CHG_WINDOW cycles, not restartable
  always_ff @(posedge ref_clk_in or negedge sys_rst_n_out) begin
    if (!sys_rst_n_out) begin
      chg_en  <= WD_CTRL_RESET[WC_CHG_EN];
      chg_cnt <= 3'h0;
    end else if (open_seq) begin
      chg_en  <= 1'b1;
      chg_cnt <= CHG_WINDOW - 3'h1;
    end else if (chg_en) begin
      chg_en  <= (chg_cnt != 3'h0);
      chg_cnt <= chg_cnt - 3'h1;
    end
  end

  // watchdog counter and its one-cycle reset pulse
  always_ff @(posedge ref_clk_in or negedge sys_rst_n_out) begin
    if (!sys_rst_n_out) begin
      wd_cnt       <= '0;
      wd_rst_pulse <= 1'b0;
    end else begin
      if (wd_restart_in || !wd_run || wd_exp) begin
        wd_cnt <= '0;
      end else if (osc_tick) begin
        wd_cnt <= wd_cnt + 1'b1;
      end
      wd_rst_pulse <= exp_rst;
    end
  end

  // reset cause flags survive internal reset; hardware set beats clear
  wire [4:0] flag_set;
  assign flag_set[RS_POWER_ON] = !sync_b[SY_POWER_OK];
  assign flag_set[RS_EXTERNAL] = !sync_b[SY_EXT_N];
  assign flag_set[RS_BROWNOUT] = sync_b[SY_BROWNOUT];
  assign flag_set[RS_WATCHDOG] = wd_rst_pulse;
  assign flag_set[RS_SCAN]     = sync_b[SY_SCAN];
  wire [4:0] flag_keep = wr_st ? wr_data_in[4:0] : 5'h1F;

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_flags  <= RST_STAT_RESET;
      ref_en_out <= 1'b0;
    end else begin
      rst_flags  <= (rst_flags & flag_keep) | flag_set;
      ref_en_out <= brownout_detector_en_in |
                    ref_ctrl[RC_CMP_REF_SEL] | ref_ctrl[RC_ADC_EN];
    end
  end

  // read port: data valid only in the cycle after the strobe
  wire [7:0] wd_rd = {irq_flag, ie_eff, prescale[3], chg_en,
                      re_eff, prescale[2:0]};
  wire [7:0] rd_mux =
    (addr_in == WD_CTRL_ADDR)  ? wd_rd :
    (addr_in == REF_CTRL_ADDR) ? {6'h00, ref_ctrl} :
    (addr_in == RST_STAT_ADDR) ? {3'h0, rst_flags} : 8'h00;

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rd_data_out <= 8'h00;
    end else begin
      rd_data_out <= rd_en_in ? rd_mux : 8'h00;
    end
  end

  default clocking dcb @(posedge ref_clk_in);
  endclocking
  default disable iff (!sys_rst_n_out);

  a_pulse_one_cycle: assert property (
    wd_rst_pulse |=> !wd_rst_pulse)
    else $error("watchdog reset pulse longer than one cycle");

  a_delay_restart: assert property (
    disable iff (!rstn_in)
    wd_rst_pulse |=> (!sys_rst_n_out && dly_cnt == '0))
    else $error("delay counter did not restart after pulse");

  a_release_time: assert property (
    disable iff (!rstn_in)
    $rose(sys_rst_n_out) |-> $past(dly_cnt) == $past(dly_last))
    else $error("reset released before delay ran out");

  a_chg_window: assert property (
    open_seq |=> chg_en [*4] ##1 !chg_en)
    else $error("change enable not open for four cycles");

  a_prescale_lock: assert property (
    (wr_wd && !chg_en) |=> $stable(prescale))
    else $error("prescale changed outside the window");

  a_fuse_lock: assert property (
    fuse_on |=> (!irq_en && !irq_req_out && re_eff))
    else $error("always-on fuse did not lock the mode");

  a_flag_forces_re: assert property (
    (rd_en_in && addr_in == WD_CTRL_ADDR && wd_flag)
      |=> rd_data_out[WC_RST_EN])
    else $error("reset enable read clear while flag set");

  a_ack_clears: assert property (
    (irq_ack_in && !exp_irq) |=> !irq_flag)
    else $error("interrupt flag survived acknowledge");

  a_ack_to_reset: assert property (
    (irq_ack_in && ie_eff && re_eff && !wr_wd) |=> !irq_en)
    else $error("combined mode did not fall back to reset mode");

  a_second_expiry: assert property (
    (wd_exp && ie_eff && re_eff && irq_flag) |=> wd_rst_pulse)
    else $error("second expiry in combined mode gave no reset");

  a_irq_request: assert property (
    (exp_irq && !wr_wd && !irq_ack_in) |=> (irq_flag && irq_req_out))
    else $error("expiry in interrupt mode raised no request");

  a_restart_clears: assert property (
    wd_restart_in |=> wd_cnt == '0)
    else $error("restart did not clear the watchdog counter");

  a_ref_enable: assert property (
    (ref_ctrl != 2'h0) |=> ref_en_out)
    else $error("reference not enabled for comparator or converter");

  a_ref_disable: assert property (
    (!brownout_detector_en_in && ref_ctrl == 2'h0) |=> !ref_en_out)
    else $error("reference enabled with no user");

  a_irq_set_wins: assert property (
    exp_irq |=> irq_flag)
    else $error("interrupt flag lost an expiry");

  a_wd_flag_set: assert property (
    disable iff (!rstn_in)
    wd_rst_pulse |=> rst_flags[RS_WATCHDOG])
    else $error("watchdog reset left no cause flag");

  a_source_holds: assert property (
    disable iff (!rstn_in)
    src_active |-> !sys_rst_n_out)
    else $error("internal reset high while a source is active");

  a_stopped_idle: assert property (
    !wd_run |=> wd_cnt == '0)
    else $error("stopped watchdog kept counting");

  a_window_take: assert property (
    win_wr |=> prescale == $past(wr_prescale))
    else $error("window write did not load the prescale");

  a_rst_en_sticky: assert property (
    (wr_wd && !chg_en && rst_en) |=> rst_en)
    else $error("reset enable cleared outside the window");

  a_req_needs_flag: assert property (
    irq_req_out |-> (irq_flag && irq_en))
    else $error("interrupt request without flag and enable");

  c_change_seq: cover property (open_seq ##[1:4] win_wr);
  c_combined_irq: cover property (exp_irq && re_eff);
  c_wd_reset: cover property (wd_rst_pulse);
  c_release: cover property (disable iff (!rstn_in) $rose(sys_rst_n_out));

endmodule : rwc_reset_watchdog

`default_nettype wire

/* File: bench/rwc_core_model.sv */
`timescale 1ns/1ps
`default_nettype none

// stands for the processor core and the supply and pin detectors
module rwc_core_model #(
  parameter int OSC_HALF_NS = 100
) (
  input  wire logic ref_clk_in,
  output logic      power_ok_out,
  output logic      ext_rst_n_out,
  output logic      brownout_low_out,
  output logic      scan_rst_out,
  output logic      wd_osc_out,
  output logic      wd_restart_out,
  output logic      irq_ack_out
);
  initial begin
    power_ok_out     = 1'b1;
    ext_rst_n_out    = 1'b1;
    brownout_low_out = 1'b0;
    scan_rst_out     = 1'b0;
    wd_restart_out   = 1'b0;
    irq_ack_out      = 1'b0;
    wd_osc_out       = 1'b0;
    // sped up far beyond the real slow oscillator to keep runs short
    forever #(OSC_HALF_NS) wd_osc_out = ~wd_osc_out;
  end

  // the released pin sits at its pull-up level
  task automatic fault(input int k, input logic on);
    @(posedge ref_clk_in);
    case (k)
      0: power_ok_out <= ~on;
      1: ext_rst_n_out <= ~on;
      2: brownout_low_out <= on;
      default: scan_rst_out <= on;
    endcase
  endtask : fault

  // one-cycle restart instruction or vector taken
  task automatic pulse(input bit ack);
    @(posedge ref_clk_in);
    if (ack) irq_ack_out <= 1'b1;
    else wd_restart_out <= 1'b1;
    @(posedge ref_clk_in);
    irq_ack_out    <= 1'b0;
    wd_restart_out <= 1'b0;
  endtask : pulse
endmodule : rwc_core_model

`default_nettype wire

/* File: bench/reset_and_watchdog_control_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module reset_and_watchdog_control_tb_top;
  import rwc_pkg::*;
  localparam int DLY  = 4;
  localparam int WDB  = 4;
  localparam int TICK = 40;
  logic            ref_clk_in, rstn_in, bod_en, aon, we, re;
  logic      [1:0] startup_time_fuse;
  logic      [3:0] cks;
  logic      [7:0] addr, wdat, r;
  wire logic       pok, ext_n, bod_low, scan, osc, restart, ack;
  wire logic       srst_n, irq, ref_en;
  wire logic [7:0] rdat;
  int              bad_count, checks_done, seed, n;

  rwc_reset_watchdog #(.DLY_BASE(DLY), .WD_BASE(WDB)) i_rwc_reset_watchdog (
    .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .power_ok_in(pok),
    .ext_rst_n_in(ext_n), .brownout_low_in(bod_low),
    .brownout_detector_en_in(bod_en), .scan_rst_in(scan), .wd_osc_in(osc),
    .startup_time_fuse_in(startup_time_fuse), .clock_select_fuse_in(cks),
    .watchdog_always_on_fuse_in(aon), .wd_restart_in(restart),
    .irq_ack_in(ack), .addr_in(addr), .wr_data_in(wdat), .wr_en_in(we),
    .rd_en_in(re), .rd_data_out(rdat), .sys_rst_n_out(srst_n),
    .irq_req_out(irq), .ref_en_out(ref_en));

  rwc_core_model i_rwc_core_model (
    .ref_clk_in(ref_clk_in), .power_ok_out(pok), .ext_rst_n_out(ext_n),
    .brownout_low_out(bod_low), .scan_rst_out(scan), .wd_osc_out(osc),
    .wd_restart_out(restart), .irq_ack_out(ack));

  initial begin
    ref_clk_in = 1'b0;
    forever #2.5 ref_clk_in = ~ref_clk_in;
  end

  function automatic int wd_cycles(input int p);
    return (WDB << (p > 9 ? 9 : p)) * TICK;
  endfunction : wd_cycles

  // release delay: base stretched by clock-select bit 3 and start-up time
  function automatic int dly_cycles(input logic [3:0] c, input int s);
    return DLY << {c[3], 2'(s)};
  endfunction : dly_cycles

  function automatic logic [7:0] flag_of(input int k);
    int pos[4] = '{RS_POWER_ON, RS_EXTERNAL, RS_BROWNOUT, RS_SCAN};
    return 8'h01 << pos[k];
  endfunction : flag_of

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    addr <= a;
    wdat <= d;
    we   <= 1'b1;
    @(posedge ref_clk_in);
    we <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk_in);
    addr <= a;
    re   <= 1'b1;
    @(posedge ref_clk_in);
    re <= 1'b0;
    #1 chk(rdat, exp);
  endtask : rd

  // timed change: open, then the new value, then let the window lapse
  task automatic wd_set(input logic [7:0] d);
    wr(WD_CTRL_ADDR, 8'h18);
    wr(WD_CTRL_ADDR, d);
    repeat (4) @(posedge ref_clk_in);
  endtask : wd_set

  task automatic wait_lvl(input bit is_irq, input logic lvl, input int lim);
    n = 0;
    do begin
      @(posedge ref_clk_in);
      #1 n++;
    end while (((is_irq ? irq : srst_n) !== lvl) && n < lim);
  endtask : wait_lvl

  // oscillator phase against the clock blurs the expiry by one tick
  task automatic in_rng(input int x);
    chk(8'(n >= x - 45 && n <= x + 45), 8'h01);
  endtask : in_rng

  task automatic end_test(input string s);
    $display("test %s done", s);
  endtask : end_test

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done

  initial begin
    repeat (40000) @(posedge ref_clk_in);
    bad_count++;
    test_done();
  end

  initial begin
    seed = 77309;
    {rstn_in, bod_en, aon, we, re, startup_time_fuse, cks, addr, wdat} = '0;
    bad_count = 0;
    checks_done = 0;
    repeat (10) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    wait_lvl(0, 1'b1, 100);
    chk(8'(n), 8'(DLY));
    rd(RST_STAT_ADDR, 8'h01);
    rd(WD_CTRL_ADDR, 8'h00);
    rd(REF_CTRL_ADDR, 8'h00);
    rd(8'h63, 8'h00);
    end_test("reset values");
    repeat (8) begin
      r = 8'($random(seed));
      wr(REF_CTRL_ADDR, r);
      bod_en <= r[7];
      @(posedge ref_clk_in);
      #1 chk({7'h0, ref_en}, {7'h0, r[7] | r[0] | r[1]});
      rd(REF_CTRL_ADDR, r & 8'h03);
      r = 8'($random(seed)) & 8'hE7;
      wr(WD_CTRL_ADDR, r);
      rd(WD_CTRL_ADDR, r & 8'h40);
    end
    i_rwc_core_model.pulse(1'b0);
    wr(WD_CTRL_ADDR, 8'h00);
    bod_en <= 1'b0;
    end_test("random registers");
    i_rwc_core_model.fault(2, 1'b1);
    repeat (3) @(posedge ref_clk_in);
    #1 chk({7'h0, srst_n}, 8'h01);
    i_rwc_core_model.fault(2, 1'b0);
    bod_en <= 1'b1;
    @(posedge ref_clk_in);
    #1 chk({7'h0, ref_en}, 8'h01);
    wr(RST_STAT_ADDR, 8'h00);
    for (int k = 0; k < 4; k++) begin
      @(posedge ref_clk_in);
      startup_time_fuse <= 2'(k);
      cks <= {1'(k == 1), 3'($random(seed))};
      i_rwc_core_model.fault(k, 1'b1);
      #1 chk({7'h0, srst_n}, 8'h00);
      repeat (3) @(posedge ref_clk_in);
      i_rwc_core_model.fault(k, 1'b0);
      wait_lvl(0, 1'b1, 300);
      chk(8'(n), 8'(dly_cycles(cks, k)));
      rd(RST_STAT_ADDR, flag_of(k));
      wr(RST_STAT_ADDR, 8'h00);
    end
    startup_time_fuse <= 2'h0;
    cks <= 4'h0;
    end_test("reset sources");
    i_rwc_core_model.pulse(1'b0);
    wr(WD_CTRL_ADDR, 8'h40);
    wait_lvl(1, 1'b1, 2000);
    in_rng(wd_cycles(0));
    rd(WD_CTRL_ADDR, 8'hC0);
    wr(WD_CTRL_ADDR, 8'hC0);
    rd(WD_CTRL_ADDR, 8'h40);
    #1 chk({7'h0, irq}, 8'h00);
    wd_set(8'h41);
    rd(WD_CTRL_ADDR, 8'h41);
    i_rwc_core_model.pulse(1'b0);
    wait_lvl(1, 1'b1, 2000);
    in_rng(wd_cycles(1));
    i_rwc_core_model.pulse(1'b1);
    @(posedge ref_clk_in);
    #1 chk({7'h0, irq}, 8'h00);
    wr(WD_CTRL_ADDR, 8'h00);
    end_test("interrupt mode");
    wr(WD_CTRL_ADDR, 8'h18);
    rd(WD_CTRL_ADDR, 8'h19);
    repeat (4) @(posedge ref_clk_in);
    rd(WD_CTRL_ADDR, 8'h09);
    wr(WD_CTRL_ADDR, 8'h00);
    rd(WD_CTRL_ADDR, 8'h09);
    repeat (6) begin
      i_rwc_core_model.pulse(1'b0);
      repeat (100) @(posedge ref_clk_in);
    end
    #1 chk({7'h0, srst_n}, 8'h01);
    wait_lvl(0, 1'b0, 2000);
    wait_lvl(0, 1'b1, 100);
    chk(8'(n), 8'(DLY));
    rd(RST_STAT_ADDR, 8'h08);
    rd(WD_CTRL_ADDR, 8'h08);
    wd_set(8'h00);
    rd(WD_CTRL_ADDR, 8'h08);
    wr(RST_STAT_ADDR, 8'h00);
    wd_set(8'h00);
    rd(WD_CTRL_ADDR, 8'h00);
    end_test("reset mode");
    i_rwc_core_model.pulse(1'b0);
    wr(WD_CTRL_ADDR, 8'h48);
    wait_lvl(1, 1'b1, 2000);
    in_rng(wd_cycles(0));
    rd(WD_CTRL_ADDR, 8'hC8);
    i_rwc_core_model.pulse(1'b1);
    rd(WD_CTRL_ADDR, 8'h08);
    wr(WD_CTRL_ADDR, 8'h48);
    wait_lvl(1, 1'b1, 2000);
    wait_lvl(0, 1'b0, 2000);
    in_rng(wd_cycles(0));
    wait_lvl(0, 1'b1, 100);
    wr(RST_STAT_ADDR, 8'h00);
    wd_set(8'h00);
    end_test("combined mode");
    @(posedge ref_clk_in);
    aon <= 1'b1;
    rd(WD_CTRL_ADDR, 8'h08);
    wr(WD_CTRL_ADDR, 8'h40);
    rd(WD_CTRL_ADDR, 8'h08);
    @(posedge ref_clk_in);
    aon <= 1'b0;
    wd_set(8'h00);
    rd(WD_CTRL_ADDR, 8'h00);
    end_test("always-on fuse");
    test_done();
  end
endmodule : reset_and_watchdog_control_tb_top

`default_nettype wire
